// File: rtl/usl_pkg.sv
/*
  usl_pkg: register map, field positions, reset values and frame constants
  for the serial port status and line control block.
  Assumes a 32-bit AHB-Lite register bus and a 16x oversampled bit clock.
*/
package usl_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL2 = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_BAUD = 8'h10;

    // control one fields
    localparam int C1_EN = 7;
    localparam int C1_LEN9 = 6;
    localparam int C1_PAREN = 5;
    localparam int C1_PARODD = 4;
    localparam int C1_BRK = 2;
    localparam int C1_TX9 = 0;
    // control two fields
    localparam int C2_TRANSMITTER_ENABLE = 7;
    localparam int C2_RECEIVER_ENABLE = 6;
    localparam int C2_RXIE = 2;

    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [8:0] MASK9 = 9'h1ff;
    localparam logic [8:0] MASK8 = 9'h0ff;
    localparam logic [3:0] LAST_BIT9 = 4'h8;
    localparam logic [3:0] LAST_BIT8 = 4'h7;
    localparam logic [3:0] OVS_S0 = 4'h7;
    localparam logic [3:0] OVS_S1 = 4'h8;
    localparam logic [3:0] OVS_MID = 4'h9;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] BRK_BITS = 4'hd;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usl_rx_e;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} usl_tx_e;
endpackage

// File: rtl/usl_uart_core.sv
/*
  usl_uart_core: AHB-Lite register slave, receiver with a two-word buffer,
  transmitter with holding register, status flags and line control.
  Assumes one 40 MHz clock, inputs synchronous to it, and a single master.
*/
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Behaviour
// - framing error sets; status-then-data clears
// - overrun sets; blocks further transfers; sequence clears
// - receiver idle low from start to stop
// - word to data register sets available flag
// - error flags set with data availability
// - available clears after status, data read, empty
// - tx idle when empty and nothing sending
// - tx idle clears on status read, data write
// - tx empty sets on shifter take; sequence clears
// - transmitter enable also sets tx empty
// - global enable off floats the tx pin
// - disable empties buffer, resets baud counter
// - disable clears transmitter and receiver enables, errors; sets idles
// - disable aborts traffic; re-enable keeps config
// - length select picks 8 or 9 bits
// - parity enable adds generation and checking
// - parity type even or odd
// - noise flag with availability, not on overrun
// - parity error only when parity enabled
module usl_uart_core
    import usl_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxPin,
    output logic txPin,
    output logic txPinOeN,
    output logic rxIrq
);
    logic port_global_enable_q, len9_q, paren_q, parodd_q, brk_q, tx9_q;
    logic transmitter_enable_q, receiver_enable_q, rie_q, txenPrev_q;
    logic [7:0] baudDiv_q, baudCnt_q;
    logic wrValid_q;
    logic [7:0] wrAddr_q;
    logic armed_q, armRx_q, armTx_q;
    logic [31:0] hrdata_q;
    logic receive_data_available_q, feFlag_q, peFlag_q, nfFlag_q, oeFlag_q, pendV_q;
    logic [8:0] rxData_q;
    logic [11:0] pend_q;
    usl_rx_e rxSt_q;
    usl_tx_e txSt_q;
    logic [3:0] rxCnt_q, rxBit_q, txCnt_q, txBit_q;
    logic s0_q, s1_q, rxNoise_q, rxPar_q, rxDone_q, rxFe_q;
    logic [8:0] rxSh_q, txHold_q, txSh_q;
    logic transmit_empty_flag_q, transmitter_idle_flag_q, txPar_q, txPin_q, txOeN_q, rxIrq_q;

    // h-size is ignored: only whole-word transfers are expected
    wire addrPhase = hsel && htrans[1] && hready;
    wire rdStatus = addrPhase && !hwrite && haddr[7:0] == ADDR_STATUS;
    wire rdData = addrPhase && !hwrite && haddr[7:0] == ADDR_DATA;
    wire wrData = wrValid_q && wrAddr_q == ADDR_DATA;
    wire wrCtrl1 = wrValid_q && wrAddr_q == ADDR_CTRL1;
    wire wrCtrl2 = wrValid_q && wrAddr_q == ADDR_CTRL2;
    wire off = !port_global_enable_q;
    wire baudTick = baudCnt_q == baudDiv_q;
    wire clrErr = armed_q && (rdData || wrData);
    wire popNow = armRx_q && rdData;
    wire clrTx = armTx_q && wrData;
    wire txenRise = transmitter_enable_q && !txenPrev_q;
    wire txTake = txSt_q == TX_IDLE && !transmit_empty_flag_q && transmitter_enable_q && !off;
    wire [8:0] lenMask = len9_q ? MASK9 : MASK8;
    wire [3:0] lastBit = len9_q ? LAST_BIT9 : LAST_BIT8;
    wire vote = (s0_q & s1_q) | (s0_q & rxPin) | (s1_q & rxPin);
    wire receiver_idle_flag = rxSt_q == RX_IDLE;
    wire [7:0] statusVec = {peFlag_q, nfFlag_q, feFlag_q, oeFlag_q,
                            receiver_idle_flag, receive_data_available_q, transmitter_idle_flag_q, transmit_empty_flag_q};

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign txPin = txPin_q;
    assign txPinOeN = txOeN_q;
    assign rxIrq = rxIrq_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            wrValid_q <= 1'b0;
            wrAddr_q <= ADDR_STATUS;
        end else begin
            wrValid_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    // read data latched in the address phase so the data phase has no wait
    always_ff @(posedge mclk) begin
        if (srst) begin
            hrdata_q <= 32'h0;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                ADDR_STATUS: hrdata_q <= {24'h0, statusVec};
                ADDR_CTRL1: hrdata_q <= {24'h0, port_global_enable_q, len9_q, paren_q, parodd_q,
                                         1'b0, brk_q, rxData_q[8], 1'b0};
                ADDR_CTRL2: hrdata_q <= {24'h0, transmitter_enable_q, receiver_enable_q, 3'h0, rie_q, 2'h0};
                ADDR_DATA: hrdata_q <= {24'h0, rxData_q[7:0]};
                ADDR_BAUD: hrdata_q <= {24'h0, baudDiv_q};
                default: hrdata_q <= 32'h0;
            endcase
        end
    end

    // disable clears only the transmitter and receiver enables and break; line format is loaded from the same write, rie survives
    always_ff @(posedge mclk) begin
        if (srst) begin
            port_global_enable_q <= 1'b0;
            len9_q <= 1'b0;
            paren_q <= 1'b0;
            parodd_q <= 1'b0;
            brk_q <= 1'b0;
            tx9_q <= 1'b0;
            transmitter_enable_q <= 1'b0;
            receiver_enable_q <= 1'b0;
            rie_q <= 1'b0;
            baudDiv_q <= BAUD_RESET;
        end else begin
            if (wrCtrl1) begin
                port_global_enable_q <= hwdata[C1_EN];
                len9_q <= hwdata[C1_LEN9];
                paren_q <= hwdata[C1_PAREN];
                parodd_q <= hwdata[C1_PARODD];
                brk_q <= hwdata[C1_BRK] && hwdata[C1_EN];
                tx9_q <= hwdata[C1_TX9];
                if (!hwdata[C1_EN]) begin
                    transmitter_enable_q <= 1'b0;
                    receiver_enable_q <= 1'b0;
                end
            end
            if (wrCtrl2) begin
                transmitter_enable_q <= hwdata[C2_TRANSMITTER_ENABLE];
                receiver_enable_q <= hwdata[C2_RECEIVER_ENABLE];
                rie_q <= hwdata[C2_RXIE];
            end
            if (wrValid_q && wrAddr_q == ADDR_BAUD) begin
                baudDiv_q <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || off || baudTick) begin
            baudCnt_q <= 8'h0;
        end else begin
            baudCnt_q <= baudCnt_q + 8'h1;
        end
    end

    // a status read arms, the next data access uses the snapshot
    always_ff @(posedge mclk) begin
        if (srst || off) begin
            armed_q <= 1'b0;
            armRx_q <= 1'b0;
            armTx_q <= 1'b0;
        end else if (rdStatus) begin
            armed_q <= 1'b1;
            armRx_q <= receive_data_available_q;
            armTx_q <= transmit_empty_flag_q;
        end else if (rdData || wrData) begin
            armed_q <= 1'b0;
            armRx_q <= 1'b0;
            armTx_q <= 1'b0;
        end
    end

    // receiver: majority of three samples around mid-bit, disagreement is noise
    always_ff @(posedge mclk) begin
        rxDone_q <= 1'b0;
        if (srst || off || !receiver_enable_q) begin
            rxSt_q <= RX_IDLE;
            rxCnt_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxSh_q <= 9'h0;
            s0_q <= 1'b1;
            s1_q <= 1'b1;
            rxNoise_q <= 1'b0;
            rxPar_q <= 1'b0;
            rxFe_q <= 1'b0;
        end else if (rxSt_q == RX_IDLE) begin
            rxCnt_q <= 4'h0;
            rxBit_q <= 4'h0;
            rxNoise_q <= 1'b0;
            if (!rxPin) begin
                rxSt_q <= RX_START;
            end
        end else if (baudTick) begin
            rxCnt_q <= rxCnt_q + 4'h1;
            if (rxCnt_q == OVS_S0) begin
                s0_q <= rxPin;
            end
            if (rxCnt_q == OVS_S1) begin
                s1_q <= rxPin;
            end
            if (rxCnt_q == OVS_MID) begin
                if (!(s0_q == s1_q && s1_q == rxPin)) begin
                    rxNoise_q <= 1'b1;
                end
                case (rxSt_q)
                    RX_START: begin
                        if (vote) begin
                            rxSt_q <= RX_IDLE;
                        end
                    end
                    RX_DATA: rxSh_q[rxBit_q] <= vote;
                    RX_PAR: rxPar_q <= vote;
                    RX_STOP: begin
                        rxFe_q <= !vote;
                        rxDone_q <= 1'b1;
                        rxSt_q <= RX_IDLE;
                    end
                    default: rxSt_q <= RX_IDLE;
                endcase
            end
            if (rxCnt_q == OVS_LAST) begin
                case (rxSt_q)
                    RX_START: rxSt_q <= RX_DATA;
                    RX_DATA: begin
                        rxBit_q <= rxBit_q + 4'h1;
                        if (rxBit_q == lastBit) begin
                            rxSt_q <= paren_q ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: rxSt_q <= RX_STOP;
                    default: rxSt_q <= rxSt_q;
                endcase
            end
        end
    end

    // parity error only looked at with parity on
    wire rxPe = paren_q && ((^(rxSh_q & lenMask) ^ rxPar_q) != parodd_q);
    wire [11:0] rxWord = {rxNoise_q, rxPe, rxFe_q, rxSh_q & lenMask};

    // two-word receive buffer; later assignments let a set beat a clear
    always_ff @(posedge mclk) begin
        if (srst || off) begin
            receive_data_available_q <= 1'b0;
            pendV_q <= 1'b0;
            pend_q <= 12'h0;
            rxData_q <= 9'h0;
            feFlag_q <= 1'b0;
            peFlag_q <= 1'b0;
            nfFlag_q <= 1'b0;
            oeFlag_q <= 1'b0;
        end else begin
            if (clrErr) begin
                feFlag_q <= 1'b0;
                peFlag_q <= 1'b0;
                nfFlag_q <= 1'b0;
                oeFlag_q <= 1'b0;
            end
            if (popNow) begin
                if (pendV_q) begin
                    // a pop always carries the clear, so only the new word's errors stand
                    rxData_q <= pend_q[8:0];
                    feFlag_q <= pend_q[9];
                    peFlag_q <= pend_q[10];
                    nfFlag_q <= pend_q[11];
                    pendV_q <= 1'b0;
                end else begin
                    receive_data_available_q <= 1'b0;
                end
            end
            if (rxDone_q && !oeFlag_q) begin
                if (!receive_data_available_q || (popNow && !pendV_q)) begin
                    rxData_q <= rxWord[8:0];
                    receive_data_available_q <= 1'b1;
                    if (rxWord[9]) feFlag_q <= 1'b1;
                    if (rxWord[10]) peFlag_q <= 1'b1;
                    if (rxWord[11]) nfFlag_q <= 1'b1;
                end else if (!pendV_q || popNow) begin
                    pend_q <= rxWord;
                    pendV_q <= 1'b1;
                end else begin
                    oeFlag_q <= 1'b1;
                end
            end
        end
    end

    // transmitter empty and idle flags
    always_ff @(posedge mclk) begin
        if (srst || off) begin
            transmit_empty_flag_q <= 1'b1;
            transmitter_idle_flag_q <= 1'b1;
            txenPrev_q <= 1'b0;
            txHold_q <= 9'h0;
        end else begin
            txenPrev_q <= transmitter_enable_q;
            transmitter_idle_flag_q <= transmit_empty_flag_q && txSt_q == TX_IDLE && !brk_q && !clrTx;
            if (clrTx) begin
                txHold_q <= {tx9_q, hwdata[7:0]} & lenMask;
                transmit_empty_flag_q <= 1'b0;
            end
            if (txTake || txenRise) begin
                transmit_empty_flag_q <= 1'b1;
            end
        end
    end

    // transmit shifter; break holds the line low for at least 14 bit times
    always_ff @(posedge mclk) begin
        if (srst || off || !transmitter_enable_q) begin
            txSt_q <= TX_IDLE;
            txCnt_q <= 4'h0;
            txBit_q <= 4'h0;
            txSh_q <= 9'h0;
            txPar_q <= 1'b0;
        end else if (txSt_q == TX_IDLE) begin
            txCnt_q <= 4'h0;
            txBit_q <= 4'h0;
            if (txTake) begin
                txSh_q <= txHold_q;
                txPar_q <= ^txHold_q ^ parodd_q;
                txSt_q <= TX_START;
            end else if (brk_q && transmit_empty_flag_q) begin
                txSt_q <= TX_BRK;
            end
        end else if (baudTick) begin
            txCnt_q <= txCnt_q + 4'h1;
            if (txCnt_q == OVS_LAST) begin
                case (txSt_q)
                    TX_START: txSt_q <= TX_DATA;
                    TX_DATA: begin
                        txSh_q <= {1'b0, txSh_q[8:1]};
                        txBit_q <= txBit_q + 4'h1;
                        if (txBit_q == lastBit) begin
                            txSt_q <= paren_q ? TX_PAR : TX_STOP;
                        end
                    end
                    TX_PAR: txSt_q <= TX_STOP;
                    TX_STOP: txSt_q <= TX_IDLE;
                    TX_BRK: begin
                        if (txBit_q != BRK_BITS) begin
                            txBit_q <= txBit_q + 4'h1;
                        end else if (!brk_q) begin
                            txSt_q <= TX_IDLE;
                        end
                    end
                    default: txSt_q <= TX_IDLE;
                endcase
            end
        end
    end

    // the tx pin floats whenever the port or transmitter is off
    always_ff @(posedge mclk) begin
        if (srst) begin
            txPin_q <= 1'b1;
            txOeN_q <= 1'b1;
            rxIrq_q <= 1'b0;
        end else begin
            txOeN_q <= !(port_global_enable_q && transmitter_enable_q);
            rxIrq_q <= rie_q && (receive_data_available_q || oeFlag_q);
            case (txSt_q)
                TX_START: txPin_q <= 1'b0;
                TX_DATA: txPin_q <= txSh_q[0];
                TX_PAR: txPin_q <= txPar_q;
                TX_BRK: txPin_q <= 1'b0;
                default: txPin_q <= 1'b1;
            endcase
        end
    end

    property p_fe_with_receive_data_available;
        @(posedge mclk) disable iff (srst) $rose(feFlag_q) |-> receive_data_available_q;
    endproperty
    a_fe_with_receive_data_available: assert property (p_fe_with_receive_data_available) else $error("fe without data");

    property p_oe_blocks;
        @(posedge mclk) disable iff (srst)
            (oeFlag_q && rxDone_q && !popNow && !clrErr && port_global_enable_q) |=> $stable(rxData_q);
    endproperty
    a_oe_blocks: assert property (p_oe_blocks) else $error("overrun moved data");

    property p_receiver_idle_flag_start;
        @(posedge mclk) disable iff (srst)
            (receiver_idle_flag && receiver_enable_q && port_global_enable_q && !rxPin) ##1 (receiver_enable_q && port_global_enable_q) |-> !receiver_idle_flag;
    endproperty
    a_receiver_idle_flag_start: assert property (p_receiver_idle_flag_start) else $error("idle after start");

    property p_receive_data_available_set;
        @(posedge mclk) disable iff (srst)
            (rxDone_q && !receive_data_available_q && !oeFlag_q && port_global_enable_q) |=> receive_data_available_q;
    endproperty
    a_receive_data_available_set: assert property (p_receive_data_available_set) else $error("receive_data_available not set");

    property p_irq;
        @(posedge mclk) disable iff (srst) (rie_q && receive_data_available_q) |=> rxIrq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("no receive interrupt");

    property p_receive_data_available_hold;
        @(posedge mclk) disable iff (srst) (receive_data_available_q && !popNow && port_global_enable_q) |=> receive_data_available_q;
    endproperty
    a_receive_data_available_hold: assert property (p_receive_data_available_hold) else $error("receive_data_available dropped");

    property p_transmitter_idle_flag_busy;
        @(posedge mclk) disable iff (srst)
            (txSt_q != TX_IDLE && port_global_enable_q) |=> (!transmitter_idle_flag_q || !port_global_enable_q);
    endproperty
    a_transmitter_idle_flag_busy: assert property (p_transmitter_idle_flag_busy) else $error("idle while busy");

    property p_transmit_empty_flag_clear;
        @(posedge mclk) disable iff (srst) (clrTx && port_global_enable_q && !txenRise) |=> !transmit_empty_flag_q;
    endproperty
    a_transmit_empty_flag_clear: assert property (p_transmit_empty_flag_clear) else $error("transmit_empty_flag kept");

    property p_transmitter_enable_sets;
        @(posedge mclk) disable iff (srst) (txenRise && port_global_enable_q) |=> transmit_empty_flag_q;
    endproperty
    a_transmitter_enable_sets: assert property (p_transmitter_enable_sets) else $error("transmit_empty_flag not set");

    property p_float;
        @(posedge mclk) disable iff (srst) !port_global_enable_q |=> txPinOeN;
    endproperty
    a_float: assert property (p_float) else $error("pin driven");

    property p_disable;
        @(posedge mclk) disable iff (srst)
            !port_global_enable_q |=> (transmit_empty_flag_q && transmitter_idle_flag_q && !receive_data_available_q && !oeFlag_q && baudCnt_q == 8'h0);
    endproperty
    a_disable: assert property (p_disable) else $error("disable state wrong");

    property p_no_pe;
        @(posedge mclk) disable iff (srst)
            (!paren_q && !peFlag_q && !(popNow && pend_q[10])) |=> !peFlag_q;
    endproperty
    a_no_pe: assert property (p_no_pe) else $error("parity off but flagged");
endmodule

// File: verif/usl_line_partner.sv
/*
  usl_line_partner: remote serial transceiver on the far side of the line.
  Assumes the bench sets the frame format to match control one.
*/
`timescale 1ns/10ps
module usl_line_partner (
    input wire logic mclk,
    input wire logic txPin,
    input wire logic txPinOeN,
    output logic rxPin,
    input wire logic cfgLen9,
    input wire logic cfgParEn,
    input wire logic cfgParOdd
);
    logic lineTx;
    logic parOk;
    logic [8:0] got;
    logic [8:0] gotq[$];
    // released pin is pulled high
    assign lineTx = txPinOeN ? 1'b1 : txPin;
    initial rxPin = 1'b1;

    // one bit time at divisor 0; flip forces the first cycles wrong
    task drive_bit(input logic b, input int flip, input logic glitch);
        for (int c = 0; c < 16; c++) begin
            rxPin <= b ^ (c < flip) ^ (glitch && c == 9);
            @(posedge mclk);
        end
    endtask

    task send_frame(input logic [8:0] w, input logic badPar, input logic badStop,
            input logic noisy);
        drive_bit(1'b0, 0, 1'b0);
        for (int i = 0; i < (cfgLen9 ? 9 : 8); i++) begin
            drive_bit(w[i], 0, noisy && i == 0);
        end
        if (cfgParEn) begin
            drive_bit(^w ^ cfgParOdd ^ badPar, 0, 1'b0);
        end
        // low stop samples give a framing fault, then back to idle high
        drive_bit(1'b1, badStop ? 11 : 0, 1'b0);
    endtask

    // sampled on the falling edge, away from the design's updates
    always begin
        @(negedge mclk);
        if (lineTx === 1'b0) begin
            parOk = 1'b1;
            got = 9'h000;
            repeat (8) @(negedge mclk);
            for (int i = 0; i < (cfgLen9 ? 9 : 8); i++) begin
                repeat (16) @(negedge mclk);
                got[i] = lineTx;
            end
            if (cfgParEn) begin
                repeat (16) @(negedge mclk);
                parOk = (lineTx === (^got ^ cfgParOdd));
            end
            repeat (16) @(negedge mclk);
            parOk = parOk & (lineTx === 1'b1);
            gotq.push_back(got);
        end
    end
endmodule

// File: verif/tb.sv
/*
  tb: self-checking bench for usl_uart_core over AHB-Lite and the serial line.
  Assumes divisor 0 (16 cycles a bit) and the partner in usl_line_partner.
*/
`timescale 1ns/10ps
module tb;
    import usl_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, rxPin, txPin, txPinOeN, rxIrq;
    logic len9 = 1'b0, parEn = 1'b0, parOdd = 1'b0;
    logic [8:0] w, wq[$];
    logic [7:0] c1;
    int bad_count = 0, samples_checked = 0, k;
    assign hready = hreadyout;
    always #12.5 mclk = ~mclk;

    usl_uart_core dut_u(.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rxPin(rxPin), .txPin(txPin), .txPinOeN(txPinOeN), .rxIrq(rxIrq));
    usl_line_partner line_u(.mclk(mclk), .txPin(txPin), .txPinOeN(txPinOeN),
        .rxPin(rxPin), .cfgLen9(len9), .cfgParEn(parEn), .cfgParOdd(parOdd));

    task xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    // expected status; both idles and tx empty assumed settled
    function automatic logic [31:0] st(input logic pe, nf, fe, oe, receive_data_available);
        return {24'h0, pe, nf, fe, oe, 1'b1, receive_data_available, 1'b1, 1'b1};
    endfunction

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        wrap_up;
    end

    initial begin
        void'($urandom(46201));
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        rdchk(ADDR_STATUS, 32'h0b);
        rdchk(8'h14, 32'h0);
        rdchk(ADDR_CTRL1, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        xfer(ADDR_CTRL1, 1'b1, 32'h80);
        xfer(ADDR_CTRL2, 1'b1, 32'hc4);
        rdchk(ADDR_STATUS, st(0, 0, 0, 0, 0));
        chk(txPinOeN, 1'b0);
        chk(txPin, 1'b1);
        for (int m = 0; m < 8; m++) begin
            {len9, parEn, parOdd} = 3'(m);
            w = 9'($urandom()) & (len9 ? MASK9 : MASK8);
            c1 = {1'b1, len9, parEn, parOdd, 3'h0, w[8]};
            xfer(ADDR_CTRL1, 1'b1, {24'h0, c1});
            rdchk(ADDR_STATUS, st(0, 0, 0, 0, 0));
            xfer(ADDR_DATA, 1'b1, {24'h0, w[7:0]});
            repeat (4) @(posedge mclk);
            rdchk(ADDR_STATUS, 32'h09);
            for (k = 0; k < 600 && line_u.gotq.size() == 0; k++) @(posedge mclk);
            chk(line_u.gotq.size(), 1);
            if (line_u.gotq.size() != 0) chk(line_u.gotq.pop_front(), w);
            chk(line_u.parOk, 1'b1);
            repeat (40) @(posedge mclk);
            rdchk(ADDR_STATUS, st(0, 0, 0, 0, 0));
            w = 9'($urandom()) & (len9 ? MASK9 : MASK8);
            fork
                line_u.send_frame(w, m == 3, m == 2, m == 5);
                begin
                    repeat (60) @(posedge mclk);
                    xfer(ADDR_STATUS, 1'b0, 32'h0);
                    chk(rd & 32'h08, 32'h0);
                end
            join
            repeat (4) @(posedge mclk);
            chk(rxIrq, 1'b1);
            xfer(ADDR_CTRL1, 1'b0, 32'h0);
            if (len9) chk(rd[1], w[8]);
            rdchk(ADDR_STATUS, st(m == 3, m == 5, m == 2, 0, 1));
            rdchk(ADDR_DATA, {24'h0, w[7:0]});
            rdchk(ADDR_STATUS, st(0, 0, 0, 0, 0));
        end
        // two words held, the first badly framed; the third overflows, its noise lost
        for (int i = 0; i < 3; i++) begin
            w = 9'($urandom());
            wq.push_back(w);
            line_u.send_frame(w, 1'b0, i == 0, i == 2);
        end
        repeat (4) @(posedge mclk);
        rdchk(ADDR_STATUS, st(0, 0, 1, 1, 1));
        rdchk(ADDR_DATA, {24'h0, wq[0][7:0]});
        rdchk(ADDR_STATUS, st(0, 0, 0, 0, 1));
        rdchk(ADDR_DATA, {24'h0, wq[1][7:0]});
        rdchk(ADDR_STATUS, st(0, 0, 0, 0, 0));
        // disable with a word held and a frame on its way out
        line_u.send_frame(9'h0a5, 1'b0, 1'b0, 1'b0);
        xfer(ADDR_STATUS, 1'b0, 32'h0);
        xfer(ADDR_DATA, 1'b1, 32'h5a);
        repeat (40) @(posedge mclk);
        xfer(ADDR_CTRL1, 1'b1, 32'h70);
        repeat (2) @(posedge mclk);
        chk(txPinOeN, 1'b1);
        rdchk(ADDR_STATUS, 32'h0b);
        rdchk(ADDR_CTRL2, 32'h04);
        xfer(ADDR_CTRL1, 1'b1, 32'hf0);
        xfer(ADDR_CTRL1, 1'b0, 32'h0);
        chk(rd & 32'hfd, 32'hf0);
        rdchk(ADDR_STATUS, 32'h0b);
        // shifter held off: the word waits until the transmitter is enabled
        xfer(ADDR_STATUS, 1'b0, 32'h0);
        xfer(ADDR_DATA, 1'b1, 32'h3c);
        rdchk(ADDR_STATUS, 32'h08);
        xfer(ADDR_CTRL2, 1'b1, 32'h80);
        rdchk(ADDR_STATUS, 32'h09);
        // break waits for the frame to finish, then holds the line low
        xfer(ADDR_CTRL1, 1'b1, 32'hf4);
        repeat (250) @(posedge mclk);
        chk(txPin, 1'b0);
        rdchk(ADDR_STATUS, 32'h09);
        xfer(ADDR_CTRL1, 1'b1, 32'h70);
        xfer(ADDR_CTRL1, 1'b0, 32'h0);
        chk(rd & 32'hfd, 32'h70);
        wrap_up;
    end
endmodule
